// ### rtl/xrlc_defs.vh
`ifndef XRLC_DEFS_VH
`define XRLC_DEFS_VH

// clock
`define XRLC_CLK_NS 100
`define XRLC_CYC(ns) (((ns) + `XRLC_CLK_NS - 1) / `XRLC_CLK_NS)

// pin timing, ns
`define XRLC_T_CW_NS 100
`define XRLC_T_WP_NS 100
`define XRLC_T_WC_NS 75
`define XRLC_T_SP_NS 100
`define XRLC_T_RS_NS 50
`define XRLC_T_RSTP_NS 100
`define XRLC_T_IO_NS 200

// register byte offsets
`define XRLC_REG_CMD 5'h00
`define XRLC_REG_STATUS 5'h04
`define XRLC_REG_STAGED 5'h10

// command word fields
`define XRLC_CMD_OP_LO 0
`define XRLC_CMD_OP_HI 1
`define XRLC_CMD_IN_LO 4
`define XRLC_CMD_IN_HI 7
`define XRLC_CMD_OUT_LO 8
`define XRLC_CMD_OUT_HI 9
`define XRLC_CMD_DEV_LO 12
`define XRLC_CMD_DEV_HI 13

// command opcodes
`define XRLC_OP_WRITE 2'h0
`define XRLC_OP_APPLY 2'h1
`define XRLC_OP_RESET 2'h2
`define XRLC_OP_READ 2'h3

// status fields
`define XRLC_ST_BUSY 0
`define XRLC_ST_RB_LO 4
`define XRLC_ST_RB_HI 7
`define XRLC_ST_RBVALID 8
`define XRLC_ST_RBOPEN 9
`define XRLC_ST_IDLE_LO 12
`define XRLC_ST_IDLE_HI 15

// pin widths
`define XRLC_NDEV 4
`define XRLC_NOUT 4

`endif

// ### rtl/xrlc_route_mem.v
`timescale 1ns/1ns
`default_nettype none

module xrlc_route_mem (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // write port
    input wire wrEn,
    input wire [1:0] wrAddr,
    input wire [3:0] wrData,
    // read port
    input wire [1:0] rdAddr,
    output reg [3:0] rdData_q
);

    reg [3:0] mem [0:3];
    integer i;

    // copy of what was staged, kept across a device reset as the device does
    always @(posedge core_clk) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                mem[i] <= 4'hF;
            end
            rdData_q <= 4'h0;
        end else begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData_q <= mem[rdAddr];
        end
    end

endmodule // xrlc_route_mem

`default_nettype wire

// ### rtl/xrlc_ctrl.v
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "xrlc_defs.vh"

// Function
// - for a write hold chip select and direction low, strobes high
// - input select field names the input, output select field the output
// - controller may write up to three more outputs before applying
// - several devices: only the addressed device gets chip select low
// - one apply strobe to all devices copies staged routes to active
// - apply after reset restores prior routes, or restage first
// - controller asserts reset at power-up
module xrlc_ctrl (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [4:0] avAddress,
    input wire avRead,
    input wire avWrite,
    input wire [31:0] avWritedata,
    output reg [31:0] avReaddata_q,
    output reg avWaitrequest_q,
    // crosspoint control pins
    output reg [`XRLC_NDEV-1:0] chipSelectN_q,
    output reg reset_n_q,
    output reg dirSelect_q,
    output reg loadStrobeN_q,
    output reg apply_strobe_n_q,
    output reg [1:0] output_line_select_q,
    // two-way input select pins
    input wire [3:0] input_line_select_in,
    output reg [3:0] input_line_select_out_q,
    output reg input_line_select_oe_q,
    // idle flags from the device
    input wire [`XRLC_NOUT-1:0] output_idle_flag
);

    localparam [8:0] S_IDLE = 9'h001;
    localparam [8:0] S_WSET = 9'h002;
    localparam [8:0] S_WPUL = 9'h004;
    localparam [8:0] S_WHLD = 9'h008;
    localparam [8:0] S_APUL = 9'h010;
    localparam [8:0] S_RPUL = 9'h020;
    localparam [8:0] S_RREC = 9'h040;
    localparam [8:0] S_BSET = 9'h080;
    localparam [8:0] S_BCAP = 9'h100;

    // counts worked out as integers, then cut to the counter width
    localparam integer N_SET = `XRLC_CYC(`XRLC_T_CW_NS) - 1;
    localparam integer N_PUL = `XRLC_CYC(`XRLC_T_WP_NS) - 1;
    localparam integer N_HLD = `XRLC_CYC(`XRLC_T_WC_NS) - 1;
    localparam integer N_APU = `XRLC_CYC(`XRLC_T_SP_NS) - 1;
    localparam integer N_RPU = `XRLC_CYC(`XRLC_T_RSTP_NS) - 1;
    localparam integer N_REC = `XRLC_CYC(`XRLC_T_RS_NS) - 1;
    localparam integer N_RDB = `XRLC_CYC(`XRLC_T_IO_NS) - 1;
    localparam [3:0] C_SET = N_SET[3:0];
    localparam [3:0] C_PUL = N_PUL[3:0];
    localparam [3:0] C_HLD = N_HLD[3:0];
    localparam [3:0] C_APU = N_APU[3:0];
    localparam [3:0] C_RPU = N_RPU[3:0];
    localparam [3:0] C_REC = N_REC[3:0];
    localparam [3:0] C_RDB = N_RDB[3:0];

    // register select from byte address, used by read and write paths
    function [1:0] regSel;
        input [4:0] addr;
        begin
            if (addr == `XRLC_REG_CMD) begin
                regSel = 2'h1;
            end else if (addr == `XRLC_REG_STATUS) begin
                regSel = 2'h2;
            end else if ((addr & 5'h13) == `XRLC_REG_STAGED) begin
                regSel = 2'h3;
            end else begin
                regSel = 2'h0;
            end
        end
    endfunction

    reg [8:0] state_q;
    reg [8:0] state_d;
    reg [3:0] cnt_q;
    reg [3:0] cnt_d;
    reg [15:0] cmd_q;
    reg arm_q;
    reg [3:0] rback_q;
    reg rbValid_q;
    reg [`XRLC_NOUT-1:0] idleFlag_q;

    wire [1:0] wrOp = avWritedata[`XRLC_CMD_OP_HI:`XRLC_CMD_OP_LO];
    wire avReq = avRead | avWrite;
    wire idle = state_q[0];
    wire cntDone = (cnt_q == 4'h0);
    wire [1:0] selNow = regSel(avAddress);
    // command writes stall while a pin sequence runs
    wire reqOk = !(avWrite && (selNow == 2'h1) && !idle);
    wire cmdTake = avWrite && !avWaitrequest_q && (selNow == 2'h1);
    wire stageWr = cmdTake && (wrOp == `XRLC_OP_WRITE);
    // cmd_q lands on the same edge the pins are set up, so take the word being written
    wire [15:0] cmdNow = cmdTake ? avWritedata[15:0] : cmd_q;
    wire [3:0] memRd;
    wire [31:0] statusWord;

    assign statusWord = {16'h0000, idleFlag_q, 2'h0, (rback_q[3] & rbValid_q), rbValid_q,
                         rback_q, 3'h0, !idle};

    xrlc_route_mem u_mem (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wrEn(stageWr),
        .wrAddr(avWritedata[`XRLC_CMD_OUT_HI:`XRLC_CMD_OUT_LO]),
        .wrData(avWritedata[`XRLC_CMD_IN_HI:`XRLC_CMD_IN_LO]),
        .rdAddr(avAddress[3:2]),
        .rdData_q(memRd)
    );

    // avalon slave: one cycle to fetch, answer in the next, release after
    always @(posedge core_clk) begin
        if (!rst_n) begin
            avWaitrequest_q <= 1'b1;
            arm_q <= 1'b0;
            avReaddata_q <= 32'h0000_0000;
            cmd_q <= 16'h0000;
        end else if (!avWaitrequest_q) begin
            avWaitrequest_q <= 1'b1;
            arm_q <= 1'b0;
            if (cmdTake) begin
                cmd_q <= avWritedata[15:0];
            end
        end else if (avReq && !arm_q) begin
            arm_q <= 1'b1;
        end else if (avReq && reqOk) begin
            avWaitrequest_q <= 1'b0;
            case (selNow)
                2'h1: avReaddata_q <= {16'h0000, cmd_q};
                2'h2: avReaddata_q <= statusWord;
                2'h3: avReaddata_q <= {28'h0000000, memRd};
                default: avReaddata_q <= 32'h0000_0000;
            endcase
        end else if (!avReq) begin
            arm_q <= 1'b0;
        end
    end

    // sequencer next state
    always @* begin
        state_d = state_q;
        cnt_d = cntDone ? 4'h0 : cnt_q - 4'h1;
        case (state_q)
            S_IDLE: begin
                if (cmdTake) begin
                    case (wrOp)
                        `XRLC_OP_WRITE: begin
                            state_d = S_WSET;
                            cnt_d = C_SET;
                        end
                        `XRLC_OP_APPLY: begin
                            state_d = S_APUL;
                            cnt_d = C_APU;
                        end
                        `XRLC_OP_RESET: begin
                            state_d = S_RPUL;
                            cnt_d = C_RPU;
                        end
                        default: begin
                            state_d = S_BSET;
                            cnt_d = C_RDB;
                        end
                    endcase
                end
            end
            S_WSET: if (cntDone) begin
                state_d = S_WPUL;
                cnt_d = C_PUL;
            end
            S_WPUL: if (cntDone) begin
                state_d = S_WHLD;
                cnt_d = C_HLD;
            end
            S_RPUL: if (cntDone) begin
                state_d = S_RREC;
                cnt_d = C_REC;
            end
            S_BSET: if (cntDone) begin
                state_d = S_BCAP;
            end
            S_WHLD, S_APUL, S_RREC, S_BCAP: if (cntDone) begin
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end

    // power-up starts with a device reset so all switches open
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= S_RPUL;
            cnt_q <= C_RPU;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // pin drivers, registered from the state being entered
    always @(posedge core_clk) begin
        if (!rst_n) begin
            chipSelectN_q <= {`XRLC_NDEV{1'b1}};
            reset_n_q <= 1'b0;
            dirSelect_q <= 1'b0;
            loadStrobeN_q <= 1'b1;
            apply_strobe_n_q <= 1'b1;
            output_line_select_q <= 2'h0;
            input_line_select_out_q <= 4'h0;
            input_line_select_oe_q <= 1'b0;
        end else begin
            reset_n_q <= !(state_d == S_RPUL);
            // strobe reaches all devices together
            apply_strobe_n_q <= !(state_d == S_APUL);
            loadStrobeN_q <= !(state_d == S_WPUL);
            dirSelect_q <= (state_d == S_BSET) || (state_d == S_BCAP);
            // drive select pins only in write mode, never against read-back
            input_line_select_oe_q <= (state_d == S_WSET) || (state_d == S_WPUL) || (state_d == S_WHLD);
            if (state_d == S_WSET || state_d == S_BSET) begin
                input_line_select_out_q <= cmdNow[`XRLC_CMD_IN_HI:`XRLC_CMD_IN_LO];
                output_line_select_q <= cmdNow[`XRLC_CMD_OUT_HI:`XRLC_CMD_OUT_LO];
            end
            if (state_d == S_WSET || state_d == S_WPUL || state_d == S_WHLD ||
                state_d == S_BSET || state_d == S_BCAP) begin
                chipSelectN_q <= ~(4'h1 << cmdNow[`XRLC_CMD_DEV_HI:`XRLC_CMD_DEV_LO]);
            end else begin
                chipSelectN_q <= {`XRLC_NDEV{1'b1}};
            end
        end
    end

    // read-back capture and idle flag sampling
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rback_q <= 4'h0;
            rbValid_q <= 1'b0;
            idleFlag_q <= {`XRLC_NOUT{1'b0}};
        end else begin
            idleFlag_q <= output_idle_flag;
            if (state_q == S_BCAP && cntDone) begin
                rback_q <= input_line_select_in;
                rbValid_q <= 1'b1;
            end else if (cmdTake && wrOp != `XRLC_OP_READ) begin
                // a write, apply or reset makes an old read-back stale
                rbValid_q <= 1'b0;
            end
        end
    end

    // staged copy in u_mem survives a device reset, so apply alone restores
    // op sequences may repeat back to back for each output

endmodule // xrlc_ctrl

`default_nettype wire

// ### dv/xrlc_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "xrlc_defs.vh"
module xrlc_ctrl_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // crosspoint control pins
    input wire logic [`XRLC_NDEV-1:0] chipSelectN_q,
    input wire logic reset_n_q,
    input wire logic dirSelect_q,
    input wire logic loadStrobeN_q,
    input wire logic apply_strobe_n_q,
    input wire logic [1:0] output_line_select_q,
    input wire logic [3:0] input_line_select_out_q,
    input wire logic input_line_select_oe_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_wr_levels;
        !loadStrobeN_q |-> !dirSelect_q && reset_n_q && apply_strobe_n_q;
    endproperty
    a_wr_levels: assert property (p_wr_levels) else $error("write strobe with wrong levels");
    property p_cs_setup;
        $fell(loadStrobeN_q) |-> $stable(chipSelectN_q) && chipSelectN_q != 4'hF;
    endproperty
    a_cs_setup: assert property (p_cs_setup) else $error("select not set before strobe");
    // pins must not move across the strobe rise, it is the capture moment
    property p_addr_hold;
        $fell(loadStrobeN_q) |-> input_line_select_oe_q ##1 ($stable(input_line_select_out_q)
            && $stable(output_line_select_q) && $stable(chipSelectN_q) && input_line_select_oe_q);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("route pins moved at strobe");
    property p_strobe_pulse;
        $fell(loadStrobeN_q) |=> $rose(loadStrobeN_q);
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("load strobe not one cycle");
    property p_onehot;
        chipSelectN_q != 4'hF |-> $onehot(~chipSelectN_q);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one device selected");
    property p_apply;
        $fell(apply_strobe_n_q) |-> reset_n_q && loadStrobeN_q ##1 apply_strobe_n_q;
    endproperty
    a_apply: assert property (p_apply) else $error("bad apply pulse");
    property p_read_mode;
        dirSelect_q |-> loadStrobeN_q && !input_line_select_oe_q;
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("drive or strobe in read mode");
    property p_read_cs;
        $rose(dirSelect_q) |-> (chipSelectN_q != 4'hF) [*2];
    endproperty
    a_read_cs: assert property (p_read_cs) else $error("read without select");
    property p_power_reset;
        $rose(rst_n) |-> !reset_n_q ##[1:4] reset_n_q;
    endproperty
    a_power_reset: assert property (p_power_reset) else $error("no device reset at start");
    c_write: cover property ($fell(loadStrobeN_q));
    c_apply: cover property ($fell(apply_strobe_n_q));
    c_read: cover property ($rose(dirSelect_q));
endmodule // xrlc_ctrl_asserts
bind xrlc_ctrl xrlc_ctrl_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n), .chipSelectN_q(chipSelectN_q),
    .reset_n_q(reset_n_q), .dirSelect_q(dirSelect_q), .loadStrobeN_q(loadStrobeN_q),
    .apply_strobe_n_q(apply_strobe_n_q), .output_line_select_q(output_line_select_q),
    .input_line_select_out_q(input_line_select_out_q), .input_line_select_oe_q(input_line_select_oe_q));
`default_nettype wire

// ### dv/xrlc_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module xrlc_dev_model (
    // clock only for the floating pin pattern
    input wire logic core_clk,
    // control pins
    input wire logic chipSelectN,
    input wire logic reset_n,
    input wire logic dirSelect,
    input wire logic loadStrobeN,
    input wire logic apply_strobe_n,
    input wire logic [1:0] output_line_select,
    // input select pins
    input wire logic [3:0] pinLevel,
    output logic devOe,
    output logic [3:0] devVal,
    // idle flags, pull-up assumed
    output logic [3:0] output_idle_flag
);
    logic [3:0] staged [4];
    logic [3:0] active [4];
    logic [3:0] junk = 4'h5;
    initial for (int j = 0; j < 4; j++) begin
        staged[j] = 4'hF;
        active[j] = 4'hF;
    end
    always @(posedge core_clk) junk <= ~junk;
    always @(posedge loadStrobeN) if (!chipSelectN && !dirSelect && reset_n && apply_strobe_n)
        staged[output_line_select] = pinLevel;
    always @(posedge apply_strobe_n) if (reset_n) for (int j = 0; j < 4; j++) active[j] = staged[j];
    always @(negedge reset_n) for (int j = 0; j < 4; j++) active[j] = 4'hF;
    // one code per output: never two inputs on one output
    assign devOe = !chipSelectN && dirSelect;
    assign devVal = devOe ? active[output_line_select] : junk;
    assign output_idle_flag = {reset_n && active[3] < 4'h8, reset_n && active[2] < 4'h8,
        reset_n && active[1] < 4'h8, reset_n && active[0] < 4'h8};
endmodule // xrlc_dev_model
`default_nettype wire

// ### dv/crosspoint_route_latch_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module crosspoint_route_latch_control_tb;
    logic core_clk = 0, rst_n = 0, avRead = 0, avWrite = 0;
    logic [4:0] avAddress = 5'h00;
    logic [31:0] avWritedata = 32'h0, avReaddata_q, st;
    logic avWaitrequest_q, reset_n_q, dirSelect_q, loadStrobeN_q, apply_strobe_n_q, ilsOe, devOe;
    logic [3:0] chipSelectN_q, ilsOut, devVal, ilsPin, idle;
    logic [1:0] outSel;
    int err_count = 0, num_checks = 0;
    logic [3:0] csSeen = 4'h0;
    logic [3:0] ins [4] = '{4'h3, 4'h3, 4'h3, 4'h7};
    always #50 core_clk = ~core_clk;
    assign ilsPin = ilsOe ? ilsOut : devVal;
    // every device ever selected; only devices 0 and 1 are addressed
    always @(posedge core_clk) if (rst_n) csSeen <= csSeen | ~chipSelectN_q;
    xrlc_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
        .avWritedata(avWritedata), .avReaddata_q(avReaddata_q), .avWaitrequest_q(avWaitrequest_q),
        .chipSelectN_q(chipSelectN_q), .reset_n_q(reset_n_q), .dirSelect_q(dirSelect_q),
        .loadStrobeN_q(loadStrobeN_q), .apply_strobe_n_q(apply_strobe_n_q), .output_line_select_q(outSel),
        .input_line_select_in(ilsPin), .input_line_select_out_q(ilsOut), .input_line_select_oe_q(ilsOe),
        .output_idle_flag(idle));
    xrlc_dev_model dev (.core_clk(core_clk), .chipSelectN(chipSelectN_q[0]), .reset_n(reset_n_q),
        .dirSelect(dirSelect_q), .loadStrobeN(loadStrobeN_q), .apply_strobe_n(apply_strobe_n_q),
        .output_line_select(outSel), .pinLevel(ilsPin), .devOe(devOe), .devVal(devVal), .output_idle_flag(idle));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // contention: the device drives the select pins while the controller does
    always @(posedge core_clk) if (devOe === 1'b1) chk(ilsOe, 1'b0);
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avAddress <= a;
        avWritedata <= d;
        avWrite <= wr;
        avRead <= !wr;
        do @(posedge core_clk);
        while (avWaitrequest_q !== 1'b0);
        st = avReaddata_q;
        avWrite <= 1'b0;
        avRead <= 1'b0;
    endtask
    // polls status so every command leaves st holding the idle status
    task automatic cmd(input logic [1:0] op, input logic [3:0] in, input logic [1:0] o, input logic [1:0] dv);
        bus(1'b1, 5'h00, {18'h0, dv, 2'h0, o, in, 2'h0, op});
        do bus(1'b0, 5'h04, 32'h0);
        while (st[0] !== 1'b0);
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        results();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        cmd(2'h1, 4'h0, 2'h0, 2'h0);
        chk(st[15:12], 4'h0);
        for (int j = 0; j < 4; j++) begin
            bus(1'b0, 5'h10 + 5'(4 * j), 32'h0);
            chk(st, 32'h0000000F);
        end
        bus(1'b0, 5'h08, 32'h0);
        chk(st, 32'h0);
        $display("reset test done");
        for (int j = 0; j < 4; j++) begin
            cmd(2'h0, ins[j], 2'(j), 2'h0);
            chk(dev.staged[j], ins[j]);
        end
        chk(idle, 4'h0);
        cmd(2'h1, 4'h0, 2'h0, 2'h0);
        chk(idle, 4'hF);
        chk(st[15:12], 4'hF);
        for (int j = 0; j < 4; j++) begin
            cmd(2'h3, 4'h0, 2'(j), 2'h0);
            chk(st[9:4], {2'h1, ins[j]});
        end
        $display("route test done");
        cmd(2'h0, 4'h5, 2'h0, 2'h0);
        cmd(2'h3, 4'h0, 2'h0, 2'h0);
        chk(st[9:4], 6'h13);
        cmd(2'h0, 4'h0, 2'h1, 2'h1);
        chk(dev.staged[1], 4'h3);
        cmd(2'h0, 4'h9, 2'h3, 2'h0);
        bus(1'b0, 5'h00, 32'h0);
        chk(st, 32'h00000390);
        cmd(2'h1, 4'h0, 2'h0, 2'h0);
        chk(idle, 4'h7);
        cmd(2'h3, 4'h0, 2'h3, 2'h0);
        chk(st[9:4], 6'h39);
        $display("staging test done");
        cmd(2'h2, 4'h0, 2'h0, 2'h0);
        chk(idle, 4'h0);
        cmd(2'h3, 4'h0, 2'h0, 2'h0);
        chk(st[9:4], 6'h3F);
        chk(dev.staged[0], 4'h5);
        cmd(2'h1, 4'h0, 2'h0, 2'h0);
        chk(idle, 4'h7);
        cmd(2'h3, 4'h0, 2'h0, 2'h0);
        chk(st[9:4], 6'h15);
        $display("device reset test done");
        chk(csSeen, 4'h3);
        results();
    end
endmodule // crosspoint_route_latch_control_tb
`default_nettype wire
